/* File: bench/fsw_checker.sv */
// Port-level assertions for the frequency selection block
`timescale 1ns/1ns
module fsw_checker (
    input wire logic        i_core_clk,
    input wire logic        i_resetn,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic [11:0] o_cpu_freq,
    input wire logic [11:0] o_mid_rate_freq,
    input wire logic [11:0] o_pci_freq,
    input wire logic [11:0] o_gear_constant,
    input wire logic        o_prog_mode,
    input wire logic        o_sys_resetn
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_spare; i_reg_rd && i_reg_addr inside {8'h10, 8'h11} |-> o_reg_rdata == 8'h00; endproperty
    a_spare: assert property (p_spare) else $error("spare byte not zero");
    property p_vendor; i_reg_rd && i_reg_addr == 8'h0f |-> o_reg_rdata == 8'h03; endproperty
    a_vendor: assert property (p_vendor) else $error("vendor byte wrong");
    property p_set0; !o_prog_mode && o_cpu_freq == 12'h3ef |-> o_mid_rate_freq == 12'h29f; endproperty
    a_set0: assert property (p_set0) else $error("set 0 ratio wrong");
    property p_set27; o_cpu_freq == 12'h7d4 |-> o_mid_rate_freq == 12'h29c && o_pci_freq == 12'h14e;
    endproperty
    a_set27: assert property (p_set27) else $error("set 27 ratio wrong");
    property p_gear; o_cpu_freq != 12'h000 |-> o_gear_constant == 12'h1e0; endproperty
    a_gear: assert property (p_gear) else $error("gear constant wrong");
    property p_pulse;
        $fell(o_sys_resetn) |-> !o_sys_resetn [*8] ##1 !o_sys_resetn [*8] ##1 !o_sys_resetn
        ##1 o_sys_resetn;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
    property p_w1c;
        i_reg_wr && i_reg_addr == 8'h17 && i_reg_wdata[1] ##2 i_reg_rd && i_reg_addr == 8'h17
        |-> !o_reg_rdata[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("expired flag not cleared");
    property p_disarm;
        i_reg_wr && i_reg_addr == 8'h17 && !i_reg_wdata[0] && o_sys_resetn |=> o_sys_resetn [*8];
    endproperty
    a_disarm: assert property (p_disarm) else $error("reset while disarmed");
endmodule

/* File: bench/host_model.sv */
// Host controller model driving the byte-wide register port
`timescale 1ns/1ns
module host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= (a == 8'h0f) ? (d | 8'h03) : d;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_core_clk);
        d = i_rdata;
        o_rd <= 1'b0;
        o_addr <= ~a;
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the frequency selection and watchdog recovery block
`timescale 1ns/1ns
module testbench;
    logic        clk;
    logic        resetn;
    logic [4:0]  strap;
    logic        wr, rd, prog, sys_n;
    logic [7:0]  addr, wdata, rdata, rv, n, rn;
    logic [11:0] cpu, mid, pci, gear;
    logic [7:0]  pll_n;
    logic [6:0]  pll_m, m, rm;
    logic [4:0]  c;
    logic [4:0]  codes [4] = '{5'h00, 5'h1b, 5'h1f, 5'h08};
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    host_model host (.i_core_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    freq_select_watchdog_recovery #(.WD_TIMEOUT(20)) dut (.i_core_clk(clk), .i_resetn(resetn),
        .i_strap_freq_code(strap), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_cpu_freq(cpu), .o_mid_rate_freq(mid),
        .o_pci_freq(pci), .o_gear_constant(gear), .o_pll_n(pll_n), .o_pll_m(pll_m),
        .o_prog_mode(prog), .o_sys_resetn(sys_n));
    function automatic logic [35:0] exp_set(input logic [4:0] code);
        case (code)
            5'h00: return {12'h3ef, 12'h29f, 12'h150};
            5'h1b: return {12'h7d4, 12'h29c, 12'h14e};
            5'h1f: return {12'h535, 12'h29a, 12'h14d};
            default: return {12'h4ec, 12'h276, 12'h13b};
        endcase
    endfunction
    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic check_set(input logic [4:0] code);
        logic [35:0] e;
        e = exp_set(code);
        check("cpu_freq", cpu, e[35:24]);
        check("mid_rate_freq", mid, e[23:12]);
        check("pci_freq", pci, e[11:0]);
    endtask
    task automatic wait_sys(input logic lvl);
        int k;
        k = 0;
        while (sys_n !== lvl && k < 60) begin
            @(posedge clk);
            k++;
        end
        check("sys_resetn", {11'h0, sys_n}, {11'h0, lvl});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        resetn = 1'b0;
        strap = 5'h1b;
        void'($urandom(32'h06af268b));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        check_set(5'h1b);
        for (int i = 0; i < 3; i++) begin
            host.wr(8'h0f + 8'(i), 8'($urandom));
            host.rd(8'h0f + 8'(i), rv);
            check("reserved", {4'h0, rv}, (i == 0) ? 12'h003 : 12'h000);
        end
        host.wr(8'h12, 8'h7f);
        host.rd(8'h12, rv);
        check("freq_control", {4'h0, rv}, 12'h03f);
        for (int i = 0; i < 6; i++) begin
            c = codes[$urandom % 4];
            host.wr(8'h12, {3'b001, c});
            repeat (2) @(posedge clk);
            check_set(c);
        end
        n = 8'($urandom);
        m = 7'($urandom);
        host.wr(8'h15, n);
        host.wr(8'h16, {1'b0, m});
        host.wr(8'h12, 8'h80);
        repeat (2) @(posedge clk);
        check("prog_n", {4'h0, pll_n}, {4'h0, n});
        check("prog_m", {5'h0, pll_m}, {5'h0, m});
        check("prog_mode", {11'h0, prog}, 12'h001);
        check("gear", gear, 12'h1e0);
        // Armed before the change, recovery from the straps
        host.wr(8'h17, 8'h01);
        host.wr(8'h12, 8'h3f);
        wait_sys(1'b0);
        host.wr(8'h17, 8'h01);
        host.rd(8'h17, rv);
        check("expired", {11'h0, rv[1]}, 12'h001);
        check("prog_mode", {11'h0, prog}, 12'h000);
        check_set(5'h1b);
        wait_sys(1'b1);
        host.wr(8'h17, 8'h02);
        host.rd(8'h17, rv);
        check("expired", {11'h0, rv[1]}, 12'h000);
        // Recovery from the programmed recovery divider values
        rn = 8'($urandom);
        rm = 7'($urandom);
        host.wr(8'h13, rn);
        host.wr(8'h14, {1'b0, rm});
        host.wr(8'h17, 8'h09);
        host.wr(8'h12, 8'h00);
        wait_sys(1'b0);
        repeat (2) @(posedge clk);
        check("rec_n", {4'h0, pll_n}, {4'h0, rn});
        check("rec_m", {5'h0, pll_m}, {5'h0, rm});
        check("prog_mode", {11'h0, prog}, 12'h001);
        wait_sys(1'b1);
        host.wr(8'h17, 8'h02);
        host.wr(8'h12, 8'h3f);
        // Armed and counting, then stopped before expiry
        host.wr(8'h17, 8'h01);
        host.wr(8'h12, 8'h1f);
        repeat (5) @(posedge clk);
        host.wr(8'h17, 8'h00);
        repeat (40) @(posedge clk);
        check("sys_resetn", {11'h0, sys_n}, 12'h001);
        host.rd(8'h17, rv);
        check("expired", {11'h0, rv[1]}, 12'h000);
        give_verdict();
    end
endmodule
bind freq_select_watchdog_recovery fsw_checker chk (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_cpu_freq(o_cpu_freq),
    .o_mid_rate_freq(o_mid_rate_freq), .o_pci_freq(o_pci_freq),
    .o_gear_constant(o_gear_constant), .o_prog_mode(o_prog_mode), .o_sys_resetn(o_sys_resetn));

/* File: core/freq_select_pkg.sv */
// Constants for the frequency selection and watchdog recovery block
package freq_select_pkg;
    // Register offsets, documented byte 15 and two spare bytes after it
    localparam logic [7:0] VENDOR_TEST_CONTROL_OFS = 8'h0f;
    localparam logic [7:0] SPARE_CONTROL_A_OFS     = 8'h10;
    localparam logic [7:0] SPARE_CONTROL_B_OFS     = 8'h11;
    // Block control register, recovery and programmed divider registers, watchdog control and status register
    localparam logic [7:0] FREQ_CONTROL_OFS        = 8'h12;
    localparam logic [7:0] RECOVERY_N_OFS          = 8'h13;
    localparam logic [7:0] RECOVERY_M_OFS          = 8'h14;
    localparam logic [7:0] PROG_N_OFS              = 8'h15;
    localparam logic [7:0] PROG_M_OFS              = 8'h16;
    localparam logic [7:0] WATCHDOG_CONTROL_OFS    = 8'h17;
    // Reset value and write mask of the vendor test byte
    localparam logic [7:0] VENDOR_TEST_RESET       = 8'h03;
    localparam logic [7:0] VENDOR_TEST_MASK        = 8'h03;
    // Field positions of freq_control
    localparam int FREQ_SEL_LSB      = 0;
    localparam int OVERRIDE_BIT      = 5;
    localparam int PROG_EN_BIT       = 7;
    // Field positions of watchdog_control
    localparam int WD_ARM_BIT        = 0;
    localparam int WD_EXPIRED_BIT    = 1;
    localparam int WD_RECOVERY_BIT   = 2;
    localparam int WD_FREQ_SEL_BIT   = 3;
    // Frequency units of 0.1 MHz
    localparam logic [11:0] PROG_MIN_FREQ = 12'h1f4;  // 50.0 MHz
    localparam logic [11:0] PROG_MAX_FREQ = 12'h9b0;  // 248.0 MHz
    localparam logic [11:0] GEAR_CONSTANT = 12'h1e0;  // 48.0 per output set
    // Watchdog timing
    localparam int WD_TIMEOUT_US     = 150000;
    localparam int CLK_MHZ           = 125;
    localparam int WD_TIMEOUT_CYC    = WD_TIMEOUT_US * CLK_MHZ;
    localparam int RESET_PULSE_CYC   = 16;
endpackage

/* File: core/freq_select_watchdog_recovery.sv */
// Frequency selection, programmable mode and watchdog recovery control
`timescale 1ns/1ns
module freq_select_watchdog_recovery #(
    parameter int WD_TIMEOUT = freq_select_pkg::WD_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Strap pins
    input  wire logic [4:0]  i_strap_freq_code,
    // Register port from the serial bus engine
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // Synthesizer control
    output logic      [11:0] o_cpu_freq,
    output logic      [11:0] o_mid_rate_freq,
    output logic      [11:0] o_pci_freq,
    output logic      [11:0] o_gear_constant,
    output logic      [7:0]  o_pll_n,
    output logic      [6:0]  o_pll_m,
    output logic             o_prog_mode,
    // System reset
    output logic             o_sys_resetn
);
    logic [4:0]  strap_s1_r, strap_s2_r, strap_latched_r;
    logic        strap_taken_r;
    logic [1:0]  strap_wait_r;
    logic [7:0]  vendor_test_r, freq_control_r, rec_n_r, rec_m_r, prog_n_r, prog_m_r;
    logic        wd_arm_r, wd_expired_r, wd_recovery_r, wd_freq_sel_r;
    logic        wd_running_r;
    logic [31:0] wd_count_r;
    logic [7:0]  rst_count_r;
    logic [4:0]  active_code;
    logic        freq_change;
    logic        wd_timeout;
    logic [11:0] cpu_f, mid_f, pci_f;

    // Strap synchroniser and one-time latch after reset release
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_s1_r      <= 5'h00;
            strap_s2_r      <= 5'h00;
            strap_latched_r <= 5'h00;
            strap_taken_r   <= 1'b0;
            strap_wait_r    <= 2'h0;
        end else begin
            strap_s1_r <= i_strap_freq_code;
            strap_s2_r <= strap_s1_r;
            // Latch only once the second stage holds a pin value
            if (!strap_taken_r) begin
                if (strap_wait_r == 2'h2) begin
                    strap_latched_r <= strap_s2_r;
                    strap_taken_r   <= 1'b1;
                end else begin
                    strap_wait_r <= strap_wait_r + 2'h1;
                end
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs);
        return i_reg_wr && (i_reg_addr == ofs);
    endfunction

    // Frequency control registers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            vendor_test_r  <= freq_select_pkg::VENDOR_TEST_RESET;
            freq_control_r <= 8'h00;
            rec_n_r        <= 8'h00;
            rec_m_r        <= 8'h00;
            prog_n_r       <= 8'h00;
            prog_m_r       <= 8'h00;
        end else begin
            if (wr_hit(freq_select_pkg::VENDOR_TEST_CONTROL_OFS)) begin
                vendor_test_r <= i_reg_wdata & freq_select_pkg::VENDOR_TEST_MASK;
            end
            if (wr_hit(freq_select_pkg::FREQ_CONTROL_OFS)) begin
                freq_control_r <= i_reg_wdata & 8'hbf;
            end
            if (wr_hit(freq_select_pkg::RECOVERY_N_OFS)) begin
                rec_n_r <= i_reg_wdata;
            end
            if (wr_hit(freq_select_pkg::RECOVERY_M_OFS)) begin
                rec_m_r <= {1'b0, i_reg_wdata[6:0]};
            end
            if (wr_hit(freq_select_pkg::PROG_N_OFS)) begin
                prog_n_r <= i_reg_wdata;
            end
            if (wr_hit(freq_select_pkg::PROG_M_OFS)) begin
                prog_m_r <= {1'b0, i_reg_wdata[6:0]};
            end
        end
    end

    // A write to freq_control or the programmed N or M register is a frequency change; recovery N/M writes are not
    // Process form so strobe and address read inside wr_hit are watched
    always_comb begin
        freq_change = wr_hit(freq_select_pkg::FREQ_CONTROL_OFS)
                   || wr_hit(freq_select_pkg::PROG_N_OFS)
                   || wr_hit(freq_select_pkg::PROG_M_OFS);
    end

    // Watchdog control and counter
    assign wd_timeout = wd_running_r && (wd_count_r == 32'h0000_0001);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wd_arm_r      <= 1'b0;
            wd_freq_sel_r <= 1'b0;
            wd_running_r  <= 1'b0;
            wd_count_r    <= 32'h0;
        end else begin
            if (wr_hit(freq_select_pkg::WATCHDOG_CONTROL_OFS)) begin
                wd_arm_r      <= i_reg_wdata[freq_select_pkg::WD_ARM_BIT];
                wd_freq_sel_r <= i_reg_wdata[freq_select_pkg::WD_FREQ_SEL_BIT];
            end
            if (!wd_arm_r || wd_timeout) begin
                wd_running_r <= 1'b0;
                wd_count_r   <= WD_TIMEOUT[31:0];
            end else if (freq_change && !wd_running_r) begin
                wd_running_r <= 1'b1;
                wd_count_r   <= WD_TIMEOUT[31:0];
            end else if (wd_running_r) begin
                wd_count_r <= wd_count_r - 32'h1;
            end
        end
    end

    // Expired flag, set wins over write-one clear
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wd_expired_r <= 1'b0;
        end else if (wd_timeout) begin
            wd_expired_r <= 1'b1;
        end else if (wr_hit(freq_select_pkg::WATCHDOG_CONTROL_OFS)
                     && i_reg_wdata[freq_select_pkg::WD_EXPIRED_BIT]) begin
            wd_expired_r <= 1'b0;
        end
    end

    // Recovery state, left by disarming the watchdog
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wd_recovery_r <= 1'b0;
        end else if (wd_timeout) begin
            wd_recovery_r <= 1'b1;
        end else if (!wd_arm_r) begin
            wd_recovery_r <= 1'b0;
        end
    end

    // System reset pulse
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_count_r <= 8'h00;
        end else if (wd_timeout) begin
            rst_count_r <= 8'(freq_select_pkg::RESET_PULSE_CYC);
        end else if (rst_count_r != 8'h00) begin
            rst_count_r <= rst_count_r - 8'h01;
        end
    end

    // Code source choice
    always_comb begin
        if (wd_recovery_r || !freq_control_r[freq_select_pkg::OVERRIDE_BIT]) begin
            active_code = strap_latched_r;
        end else begin
            active_code = freq_control_r[freq_select_pkg::FREQ_SEL_LSB +: 5];
        end
    end

    // Output set table in 0.1 MHz
    always_comb begin
        unique case (active_code)
            5'h00: {cpu_f, mid_f, pci_f} = {12'd1007, 12'd671, 12'd336};
            5'h01: {cpu_f, mid_f, pci_f} = {12'd1009, 12'd673, 12'd336};
            5'h02: {cpu_f, mid_f, pci_f} = {12'd1080, 12'd720, 12'd360};
            5'h03: {cpu_f, mid_f, pci_f} = {12'd1012, 12'd675, 12'd337};
            5'h04: {cpu_f, mid_f, pci_f} = {12'd1140, 12'd760, 12'd380};
            5'h05: {cpu_f, mid_f, pci_f} = {12'd1170, 12'd780, 12'd390};
            5'h06: {cpu_f, mid_f, pci_f} = {12'd1200, 12'd800, 12'd400};
            5'h07: {cpu_f, mid_f, pci_f} = {12'd1230, 12'd820, 12'd410};
            5'h08: {cpu_f, mid_f, pci_f} = {12'd1260, 12'd630, 12'd315};
            5'h09: {cpu_f, mid_f, pci_f} = {12'd1300, 12'd650, 12'd325};
            5'h0a: {cpu_f, mid_f, pci_f} = {12'd1339, 12'd670, 12'd335};
            5'h0b: {cpu_f, mid_f, pci_f} = {12'd1342, 12'd671, 12'd336};
            5'h0c: {cpu_f, mid_f, pci_f} = {12'd1345, 12'd673, 12'd336};
            5'h0d: {cpu_f, mid_f, pci_f} = {12'd1480, 12'd740, 12'd370};
            5'h0e: {cpu_f, mid_f, pci_f} = {12'd1520, 12'd760, 12'd380};
            5'h0f: {cpu_f, mid_f, pci_f} = {12'd1560, 12'd780, 12'd390};
            5'h10: {cpu_f, mid_f, pci_f} = {12'd1600, 12'd800, 12'd400};
            5'h11: {cpu_f, mid_f, pci_f} = {12'd1640, 12'd820, 12'd410};
            5'h12: {cpu_f, mid_f, pci_f} = {12'd1674, 12'd669, 12'd335};
            5'h13: {cpu_f, mid_f, pci_f} = {12'd1700, 12'd680, 12'd340};
            5'h14: {cpu_f, mid_f, pci_f} = {12'd1750, 12'd700, 12'd350};
            5'h15: {cpu_f, mid_f, pci_f} = {12'd1800, 12'd720, 12'd360};
            5'h16: {cpu_f, mid_f, pci_f} = {12'd1850, 12'd740, 12'd370};
            5'h17: {cpu_f, mid_f, pci_f} = {12'd1900, 12'd760, 12'd380};
            5'h18: {cpu_f, mid_f, pci_f} = {12'd1668, 12'd667, 12'd334};
            5'h19: {cpu_f, mid_f, pci_f} = {12'd1002, 12'd668, 12'd334};
            5'h1a: {cpu_f, mid_f, pci_f} = {12'd1336, 12'd668, 12'd334};
            5'h1b: {cpu_f, mid_f, pci_f} = {12'd2004, 12'd668, 12'd334};
            5'h1c: {cpu_f, mid_f, pci_f} = {12'd1666, 12'd666, 12'd333};
            5'h1d: {cpu_f, mid_f, pci_f} = {12'd1000, 12'd666, 12'd333};
            5'h1e: {cpu_f, mid_f, pci_f} = {12'd2000, 12'd666, 12'd333};
            5'h1f: {cpu_f, mid_f, pci_f} = {12'd1333, 12'd666, 12'd333};
        endcase
    end

    // Registered synthesizer outputs
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cpu_freq      <= 12'h0;
            o_mid_rate_freq <= 12'h0;
            o_pci_freq      <= 12'h0;
            o_gear_constant <= 12'h0;
            o_pll_n         <= 8'h00;
            o_pll_m         <= 7'h00;
            o_prog_mode     <= 1'b0;
            o_sys_resetn    <= 1'b1;
        end else begin
            o_cpu_freq      <= cpu_f;
            o_mid_rate_freq <= mid_f;
            o_pci_freq      <= pci_f;
            o_gear_constant <= freq_select_pkg::GEAR_CONSTANT;
            o_sys_resetn    <= (rst_count_r == 8'h00) && !wd_timeout;
            if (wd_recovery_r) begin
                o_prog_mode <= wd_freq_sel_r;
                o_pll_n     <= rec_n_r;
                o_pll_m     <= rec_m_r[6:0];
            end else begin
                o_prog_mode <= freq_control_r[freq_select_pkg::PROG_EN_BIT];
                o_pll_n     <= prog_n_r;
                o_pll_m     <= prog_m_r[6:0];
            end
        end
    end

    // Read mux; spare and unmapped bytes read zero
    always_comb begin
        o_reg_rdata = 8'h00;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                freq_select_pkg::VENDOR_TEST_CONTROL_OFS: o_reg_rdata = vendor_test_r;
                freq_select_pkg::FREQ_CONTROL_OFS:        o_reg_rdata = freq_control_r;
                freq_select_pkg::RECOVERY_N_OFS:          o_reg_rdata = rec_n_r;
                freq_select_pkg::RECOVERY_M_OFS:          o_reg_rdata = rec_m_r;
                freq_select_pkg::PROG_N_OFS:              o_reg_rdata = prog_n_r;
                freq_select_pkg::PROG_M_OFS:              o_reg_rdata = prog_m_r;
                freq_select_pkg::WATCHDOG_CONTROL_OFS:
                    o_reg_rdata = {4'h0, wd_freq_sel_r, wd_recovery_r, wd_expired_r, wd_arm_r};
                default:                                  o_reg_rdata = 8'h00;
            endcase
        end
    end
endmodule
